// File: core/sled_regs.svh
`ifndef SLED_REGS_SVH
`define SLED_REGS_SVH
// Register byte offsets
`define SLED_CTRL_OFF      4'h0
`define SLED_STAT_OFF      4'h4
// Control register fields
`define SLED_CTRL_MODE3    0
`define SLED_CTRL_RST      32'h0000_0000
// Enabled cycles after reset over which the strap is sampled
`define SLED_STRAP_CYC     3'h5
// Status register fields
`define SLED_STAT_MODE_LO  0
`define SLED_STAT_MODE_HI  2
`define SLED_STAT_LINK     3
`define SLED_STAT_SPEED    4
`define SLED_STAT_ACT      5
// Blink timing: length of the stretched off phase of the blink
`define SLED_BLINK_MS      50
`define SLED_CLK_KHZ       20000
`define SLED_BLINK_CYC     (`SLED_BLINK_MS * `SLED_CLK_KHZ)
`define SLED_CNT_W         21
// AXI responses
`define SLED_RESP_OKAY     2'h0
`define SLED_RESP_SLVERR   2'h2
`endif

// File: core/sled_pkg.sv
package sled_pkg;
   // LED operating modes, one-hot
   typedef enum logic [2:0] {
      SLED_MODE1 = 3'h1,
      SLED_MODE2 = 3'h2,
      SLED_MODE3 = 3'h4
   } sled_mode_type;
endpackage : sled_pkg

// File: core/sled_stretch.sv
`timescale 1ns/1ns
`include "sled_regs.svh"
module sled_stretch (
   input  wire logic I_CLK,
   input  wire logic I_RESET_N,
   input  wire logic I_CE,
   input  wire logic i_act,
   output logic      o_blink
);
   logic [`SLED_CNT_W-1:0] cnt_q;
   logic                   pend_q;
   logic                   blink_q;
   logic                   busy;
   logic                   wrap;
   assign busy = (cnt_q != '0);
   assign wrap = (cnt_q == `SLED_CNT_W'(`SLED_BLINK_CYC - 1));
   assign o_blink = blink_q;
   // A burst of activity from idle gives at least two off phases, each then an on phase;
   // activity during a phase is remembered so short packets are never lost; the on phase between two off phases lasts one cycle
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         cnt_q   <= '0;
         pend_q  <= 1'b0;
         blink_q <= 1'b0;
      end else if (I_CE) begin
         pend_q <= i_act | (pend_q & busy);
         if (wrap) begin
            cnt_q   <= '0;
            blink_q <= 1'b0;
         end else if (busy) begin
            cnt_q <= cnt_q + `SLED_CNT_W'(1);
         end else if (pend_q | i_act) begin
            cnt_q   <= `SLED_CNT_W'(1);
            blink_q <= ~blink_q;
         end
      end
   end
   // Off phase ends only after a full stretched interval
   AST_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && busy && !wrap) |=> $stable(blink_q))
      else $error("blink changed mid interval");
endmodule : sled_stretch

// File: core/sled_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "sled_regs.svh"
// Function
// - Three separately driven configurable LED outputs
// - Strap picks modes 1/2; register picks 3
// - Mode 1 link LED shows link only
// - Modes 2,3 link LED blinks on activity
// - Speed LED on at 100, off 10
// - Mode 1 third LED shows activity
// - Mode 2 third LED shows collision
// - Mode 3 third LED shows full duplex
module sled_top (
   input  wire logic        I_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic        I_CE,
   input  wire logic        I_MODE_STRAP,
   input  wire logic        I_LINK_GOOD,
   input  wire logic        I_SPEED_100,
   input  wire logic        I_TX_ACTIVE,
   input  wire logic        I_RX_ACTIVE,
   input  wire logic        I_COLLISION,
   input  wire logic        I_FULL_DUPLEX,
   input  wire logic [3:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [3:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output sled_pkg::sled_mode_type O_MODE,
   output logic             O_LINK_INDICATOR_OUT,
   output logic             O_SPEED_INDICATOR_OUT,
   output logic             O_ACTIVITY_INDICATOR_OUT
);
   import sled_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
   logic [6:0] s1_q;
   logic [6:0] s2_q;
   logic [6:0] s3_q;
   logic [6:0] clean_q;
   logic [6:0] pins;
   assign pins = {I_MODE_STRAP, I_FULL_DUPLEX, I_COLLISION, I_RX_ACTIVE,
                  I_TX_ACTIVE, I_SPEED_100, I_LINK_GOOD};
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_sync
         always_ff @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               s1_q[g]    <= 1'b0;
               s2_q[g]    <= 1'b0;
               s3_q[g]    <= 1'b0;
               clean_q[g] <= 1'b0;
            end else if (I_CE) begin
               s1_q[g] <= pins[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  clean_q[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate
   logic link_s, spd_s, tx_s, rx_s, col_s, fd_s, strap_s;
   assign {strap_s, fd_s, col_s, rx_s, tx_s, spd_s, link_s} = clean_q;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture after reset release; settles once synchroniser fills
   logic [2:0] strap_wait_q;
   logic       strap_q;
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         strap_wait_q <= 3'h0;
         strap_q      <= 1'b0;
      end else if (I_CE && strap_wait_q != `SLED_STRAP_CYC) begin
         strap_wait_q <= strap_wait_q + 3'h1;
         strap_q      <= strap_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: addr and data taken in either order, reply after both
   logic        ctrl_q;
   logic        aw_q, w_q, bvalid_q, rvalid_q, wstrb0_q;
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0]  bresp_q, rresp_q;
   logic        wr_fire, ctrl_hit, rd_ctrl, rd_stat;
   logic [31:0] stat_word;
   // Handshakes gated by the enable: a frozen slave must not take or answer
   assign S_AXI_AWREADY = I_CE && !aw_q && !bvalid_q;
   assign S_AXI_WREADY  = I_CE && !w_q && !bvalid_q;
   assign S_AXI_ARREADY = I_CE && !rvalid_q;
   assign S_AXI_BVALID  = I_CE && bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_RVALID  = I_CE && rvalid_q;
   assign S_AXI_RDATA   = rdata_q;
   assign S_AXI_RRESP   = rresp_q;
   assign wr_fire  = aw_q && w_q && !bvalid_q;
   assign ctrl_hit = (awaddr_q == `SLED_CTRL_OFF);
   assign rd_ctrl  = (S_AXI_ARADDR == `SLED_CTRL_OFF);
   assign rd_stat  = (S_AXI_ARADDR == `SLED_STAT_OFF);
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q  <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= `SLED_RESP_OKAY;
         ctrl_q   <= 1'(`SLED_CTRL_RST);
      end else if (I_CE) begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_q     <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_q     <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb0_q <= S_AXI_WSTRB[0]; // Strobe kept; master may drop it once taken
         end
         if (wr_fire) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= (ctrl_hit || awaddr_q == `SLED_STAT_OFF) ?
                        `SLED_RESP_OKAY : `SLED_RESP_SLVERR;
            if (ctrl_hit && wstrb0_q) begin
               ctrl_q <= wdata_q[`SLED_CTRL_MODE3];
            end
         end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   // Read path answers one cycle after the address is taken
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `SLED_RESP_OKAY;
      end else if (I_CE) begin
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_ctrl ? {31'h0000_0000, ctrl_q} :
                        rd_stat ? stat_word : 32'h0000_0000;
            rresp_q  <= (rd_ctrl || rd_stat) ? `SLED_RESP_OKAY : `SLED_RESP_SLVERR;
         end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode select: register setting overrides the strap
   sled_mode_type mode;
   assign mode = ctrl_q ? SLED_MODE3 : (strap_q ? SLED_MODE2 : SLED_MODE1);

   // Stretched activity blink
   logic blink;
   logic act;
   assign act = tx_s | rx_s;
   sled_stretch u_stretch (
      .I_CLK     (I_CLK),
      .I_RESET_N (I_RESET_N),
      .I_CE      (I_CE),
      .i_act     (act),
      .o_blink   (blink)
   );

   ////////////////////////////////////////////////////////////////////////////
   // LED drive; in modes 2 and 3 the blink phase darkens a lit link LED
   logic link_d, third_d;
   always_comb begin
      link_d  = link_s;
      third_d = 1'b0;
      unique case (mode)
         SLED_MODE1: begin
            link_d  = link_s;
            third_d = act;
         end
         SLED_MODE2: begin
            link_d  = link_s & ~blink;
            third_d = col_s;
         end
         SLED_MODE3: begin
            link_d  = link_s & ~blink;
            third_d = fd_s;
         end
         default: begin
            link_d  = link_s;
            third_d = 1'b0;
         end
      endcase
   end
   logic link_q, speed_q, third_q;
   sled_mode_type mode_q;
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         link_q  <= 1'b0;
         speed_q <= 1'b0;
         third_q <= 1'b0;
         mode_q  <= SLED_MODE1;
      end else if (I_CE) begin
         link_q  <= link_d;
         speed_q <= spd_s;
         third_q <= third_d;
         mode_q  <= mode;
      end
   end
   assign O_LINK_INDICATOR_OUT     = link_q;
   assign O_SPEED_INDICATOR_OUT    = speed_q;
   assign O_ACTIVITY_INDICATOR_OUT = third_q;
   assign O_MODE                   = mode_q;
   assign stat_word = {26'h000_0000, third_q, speed_q, link_q, mode_q};

   ////////////////////////////////////////////////////////////////////////////
   AST_MODE1_LINK: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && mode == SLED_MODE1) |=> (O_LINK_INDICATOR_OUT == $past(link_s)))
      else $error("mode 1 link led wrong");
   AST_LINK_BLINK: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && mode != SLED_MODE1) |=> (O_LINK_INDICATOR_OUT ==
      ($past(link_s) & ~$past(blink))))
      else $error("link blink wrong");
   AST_SPEED: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      I_CE |=> (O_SPEED_INDICATOR_OUT == $past(spd_s)))
      else $error("speed led wrong");
   AST_ACT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && mode == SLED_MODE1) |=> (O_ACTIVITY_INDICATOR_OUT == $past(tx_s | rx_s)))
      else $error("activity led wrong");
   AST_COL: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && mode == SLED_MODE2) |=> (O_ACTIVITY_INDICATOR_OUT == $past(col_s)))
      else $error("collision led wrong");
   AST_FDX: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && mode == SLED_MODE3) |=> (O_ACTIVITY_INDICATOR_OUT == $past(fd_s)))
      else $error("duplex led wrong");
   AST_MODE3_REG: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && ctrl_q) |=> (O_MODE == SLED_MODE3))
      else $error("register mode not taken");
   AST_BRESP: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && wr_fire) |=> bvalid_q)
      else $error("write response missing");
endmodule : sled_top

// File: test/sled_led_model.sv
`timescale 1ns/1ns
// Board LEDs: a lit LED simply follows its high drive level
module sled_led_model (
   input  wire logic i_link,
   input  wire logic i_speed,
   input  wire logic i_third,
   output logic      o_lit_link,
   output logic      o_lit_speed,
   output logic      o_lit_third
);
   // No resistor or pull modelled, so a floating drive passes through as high impedance (z)
   assign o_lit_link  = i_link;
   assign o_lit_speed = i_speed;
   assign o_lit_third = i_third;
endmodule : sled_led_model

// File: test/sled_top_tb.sv
`timescale 1ns/1ns
`include "sled_regs.svh"
module sled_top_tb;
   import sled_pkg::*;
   logic          I_CLK, I_RESET_N, I_CE, I_MODE_STRAP;
   logic [5:0]    pins; // Link, speed, tx, rx, collision, duplex
   logic [3:0]    S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
   logic [31:0]   S_AXI_WDATA, S_AXI_RDATA;
   logic [1:0]    S_AXI_BRESP, S_AXI_RRESP;
   logic          S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic          S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic          S_AXI_RVALID, S_AXI_RREADY;
   sled_mode_type O_MODE, mode;
   logic          led_l, led_s, led_t, lit_l, lit_s, lit_t;
   int            fail_count, n_compared;
   logic [33:0]   exp_r[$], exp_b[$];
   logic [5:0]    exp_l[$];
   event          led_ev;
   logic          dark;
   logic [5:0]    last_e;

   sled_top u_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CE(I_CE),
      .I_MODE_STRAP(I_MODE_STRAP), .I_LINK_GOOD(pins[5]), .I_SPEED_100(pins[4]),
      .I_TX_ACTIVE(pins[3]), .I_RX_ACTIVE(pins[2]), .I_COLLISION(pins[1]),
      .I_FULL_DUPLEX(pins[0]), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
      .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
      .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
      .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
      .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
      .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
      .S_AXI_RREADY(S_AXI_RREADY), .O_MODE(O_MODE), .O_LINK_INDICATOR_OUT(led_l),
      .O_SPEED_INDICATOR_OUT(led_s), .O_ACTIVITY_INDICATOR_OUT(led_t));

   sled_led_model u_leds (.i_link(led_l), .i_speed(led_s), .i_third(led_t),
      .o_lit_link(lit_l), .o_lit_speed(lit_s), .o_lit_third(lit_t));

   ////////////////////////////////////////////////////////////////////////
   // Clock, 50 ns period
   initial begin
      I_CLK = 1'b0;
      forever #25 I_CLK = ~I_CLK;
   end

   task automatic stop_test;
      if (fail_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t bus resp/data exp %h got %h", $time, e, g);
      end
   endtask : cmp_bus

   task automatic cmp_led(input logic [5:0] e, input logic [5:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t mode/leds exp %h got %h", $time, e, g);
      end
   endtask : cmp_led

   // Monitor: each answer taken off the bus is matched to the oldest note
   always @(posedge I_CLK) begin
      if (S_AXI_RVALID && S_AXI_RREADY)
         cmp_bus(exp_r.pop_front(), {S_AXI_RRESP, S_AXI_RDATA});
      if (S_AXI_BVALID && S_AXI_BREADY)
         cmp_bus(exp_b.pop_front(), {S_AXI_BRESP, 32'h0000_0000});
   end

   // Monitor: LED snapshot once the driver says inputs have settled
   always @(led_ev)
      cmp_led(exp_l.pop_front(), {O_MODE, lit_l, lit_s, lit_t});

   ////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w;
      exp_b.push_back({r, 32'h0000_0000});
      @(posedge I_CLK);
      S_AXI_AWADDR  <= a;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WDATA   <= d;
      S_AXI_WSTRB   <= 4'hf;
      S_AXI_WVALID  <= 1'b1;
      S_AXI_BREADY  <= 1'b1;
      aw = 1'b0;
      w  = 1'b0;
      // Each channel released only at the edge where its ready is seen
      while (!(aw && w)) begin
         @(posedge I_CLK);
         if (!aw && S_AXI_AWREADY === 1'b1) begin
            aw = 1'b1;
            S_AXI_AWVALID <= 1'b0;
         end
         if (!w && S_AXI_WREADY === 1'b1) begin
            w = 1'b1;
            S_AXI_WVALID <= 1'b0;
         end
      end
      while (S_AXI_BVALID !== 1'b1)
         @(posedge I_CLK);
      S_AXI_BREADY <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
      exp_r.push_back(e);
      @(posedge I_CLK);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY  <= 1'b1;
      do
         @(posedge I_CLK);
      while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      while (S_AXI_RVALID !== 1'b1)
         @(posedge I_CLK);
      S_AXI_RREADY <= 1'b0;
   endtask : axi_rd

   // Drive the status pins, let the sync chain settle, then note the LEDs
   task automatic leds(input logic [5:0] p);
      logic th;
      logic lk;
      @(posedge I_CLK);
      pins <= p;
      repeat (8) @(posedge I_CLK);
      th = (mode == SLED_MODE1) ? (p[3] | p[2]) : (mode == SLED_MODE2) ? p[1] : p[0];
      // Traffic opens a dark stretched phase that outlasts the whole run
      if (p[3] | p[2])
         dark = 1'b1;
      lk = p[5] & ~(dark && mode != SLED_MODE1);
      last_e = {mode, lk, p[4], th};
      exp_l.push_back(last_e);
      -> led_ev;
      axi_rd(`SLED_STAT_OFF, {`SLED_RESP_OKAY, 26'h0, th, p[4], lk, mode});
   endtask : leds

   // Enable low: new pins must leave every LED as it was, then pins restored
   task automatic freeze(input logic [5:0] p);
      logic [5:0] keep;
      keep = pins;
      @(posedge I_CLK);
      I_CE <= 1'b0;
      pins <= p;
      repeat (8) @(posedge I_CLK);
      exp_l.push_back(last_e);
      -> led_ev;
      pins <= keep;
      @(posedge I_CLK);
      I_CE <= 1'b1;
   endtask : freeze

   task automatic do_reset(input logic s);
      @(posedge I_CLK);
      I_RESET_N    <= 1'b0;
      I_MODE_STRAP <= s;
      pins         <= 6'h00;
      repeat (10) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      mode = s ? SLED_MODE2 : SLED_MODE1;
      dark = 1'b0;
      // Strap is sampled over the first enabled cycles, so hold it
      repeat (8) @(posedge I_CLK);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////
   // Main sequence; once traffic is seen the link LED of modes 2 and 3 stays
   // dark, since the first blink phase outlasts the whole run
   initial begin
      {I_RESET_N, I_MODE_STRAP, pins, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB} = '0;
      {S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
      {S_AXI_ARVALID, S_AXI_RREADY} = '0;
      I_CE = 1'b1;
      void'($urandom(11));
      do_reset(1'b0);
      repeat (6) leds(6'($urandom));
      freeze(6'($urandom));
      axi_rd(4'h8, {`SLED_RESP_SLVERR, 32'h0000_0000});
      axi_wr(4'hc, 32'h0000_0001, `SLED_RESP_SLVERR);
      do_reset(1'b0);
      axi_rd(`SLED_CTRL_OFF, {`SLED_RESP_OKAY, `SLED_CTRL_RST});
      axi_wr(`SLED_CTRL_OFF, 32'h0000_0001, `SLED_RESP_OKAY);
      mode = SLED_MODE3;
      axi_rd(`SLED_CTRL_OFF, {`SLED_RESP_OKAY, 32'h0000_0001});
      axi_wr(`SLED_STAT_OFF, 32'hffff_ffff, `SLED_RESP_OKAY);
      leds(6'h31);
      leds(6'h24);
      repeat (5) leds(6'($urandom));
      do_reset(1'b1);
      leds(6'h32);
      leds(6'h24);
      repeat (5) leds(6'($urandom));
      stop_test();
   end

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge I_CLK);
      fail_count++;
      stop_test();
   end
endmodule : sled_top_tb
